// ---- host_port_pkg.sv ----
// Constants and types shared by the dual-channel host bus port
// ============================================================
package host_port_pkg;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int REGS_PER_CHAN = 8;
  localparam int NUM_CHAN = 2;
  localparam int ADDR_W = 4;
  // Index of the modem control register within a channel
  localparam logic [IDX_W-1:0] MODEM_CTRL_IDX = 3'h4;
  // Field position of the irq enable / aux output control bit
  localparam int IRQ_EN_BIT = 3;
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
  // Direction line levels in direction-signal mode
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // Style pin level for separate-strobe mode
  localparam logic STYLE_STROBE = 1'b1;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_WRITE
  } bus_state_type;
endpackage

// ---- chan_reg_mem.sv ----
// Register storage for both channels with registered read data
`timescale 1ns/1ps
`default_nettype none
module chan_reg_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 4,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  // Read port
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem_r [DEPTH];

  // Storage resets so every register has a known value
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data comes from a register, loaded on request only
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule // chan_reg_mem
`default_nettype wire

// ---- dual_channel_host_bus_port.sv ----
// Host bus port: decodes both bus styles, holds channel registers
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_bus_port (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Bus style select
  input wire logic bus_style_i,
  // Host bus
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic [host_port_pkg::IDX_W-1:0] register_index_i,
  input wire logic [host_port_pkg::DATA_W-1:0] data_i,
  output logic [host_port_pkg::DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  // Interrupt pins, each as output plus active-low enable
  input wire logic chan_a_irq_req_i,
  input wire logic chan_b_irq_req_i,
  output logic chan_a_irq_o,
  output logic chan_a_irq_oe_n_o,
  output logic chan_b_irq_o,
  output logic chan_b_irq_oe_n_o,
  // Auxiliary outputs
  output logic chan_a_aux_out_n_o,
  output logic chan_b_aux_out_n_o
);
  import host_port_pkg::*;

  // ==========================================================
  // Strobe decode
  // ==========================================================
  logic strobe_mode;
  logic chan_sel;
  logic selected;
  logic rd_level;
  logic wr_level;
  logic rd_level_r;
  logic wr_level_r;
  logic rd_start;
  logic wr_done;
  logic [IDX_W-1:0] idx_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] ctrl_a_r;
  logic [DATA_W-1:0] ctrl_b_r;
  bus_state_type state_r;

  assign strobe_mode = (bus_style_i == STYLE_STROBE);

  // Channel choice differs per style; strobe mode assumes at most
  // one select is low, and A wins if the host breaks that
  always_comb begin
    if (strobe_mode) begin
      selected = !chan_a_select_n_i || !chan_b_select_n_i;
      chan_sel = chan_a_select_n_i;
    end else begin
      selected = !chan_a_select_n_i;
      chan_sel = chan_b_select_n_i;
    end
  end

  // Access levels: read strobe unused in direction mode
  always_comb begin
    if (strobe_mode) begin
      rd_level = selected && !read_strobe_n_i;
      wr_level = selected && !write_strobe_n_i;
    end else begin
      rd_level = selected && (write_strobe_n_i == DIR_READ);
      wr_level = selected && (write_strobe_n_i == DIR_WRITE);
    end
  end

  // Edge history of the access levels
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_level_r <= 1'b0;
      wr_level_r <= 1'b0;
    end else begin
      rd_level_r <= rd_level;
      wr_level_r <= wr_level;
    end
  end

  assign rd_start = rd_level && !rd_level_r;
  // Write commits when access ends, i.e. at the strobe rise
  assign wr_done = !wr_level && wr_level_r && (state_r == BUS_WRITE);

  // ==========================================================
  // Transaction state
  // ==========================================================
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= BUS_IDLE;
    end else begin
      case (state_r)
        BUS_IDLE: begin
          if (rd_level) begin
            state_r <= BUS_READ;
          end else if (wr_level) begin
            state_r <= BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (!rd_level) begin
            state_r <= BUS_IDLE;
          end
        end
        BUS_WRITE: begin
          if (!wr_level) begin
            state_r <= BUS_IDLE;
          end
        end
        default: begin
          state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // Address and data are sampled while the write is open, so the
  // last byte seen before the rising edge is the one stored
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_addr_r <= '0;
      wr_data_r <= '0;
      idx_r <= '0;
    end else if (wr_level) begin
      wr_addr_r <= {chan_sel, register_index_i};
      wr_data_r <= data_i;
      idx_r <= register_index_i;
    end
  end

  // ==========================================================
  // Register storage
  // ==========================================================
  chan_reg_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .DEPTH(REGS_PER_CHAN * NUM_CHAN)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(wr_done),
    .wr_addr_i(wr_addr_r),
    .wr_data_i(wr_data_r),
    .rd_en_i(rd_start),
    .rd_addr_i({chan_sel, register_index_i}),
    .rd_data_o(rd_data)
  );

  // Shadow of each modem control register for the pin logic
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_a_r <= REG_RESET_VAL;
      ctrl_b_r <= REG_RESET_VAL;
    end else if (wr_done && idx_r == MODEM_CTRL_IDX) begin
      if (wr_addr_r[ADDR_W-1]) begin
        ctrl_b_r <= wr_data_r;
      end else begin
        ctrl_a_r <= wr_data_r;
      end
    end
  end

  // ==========================================================
  // Data bus drive
  // ==========================================================
  // Driven only while the read is open; one cycle after the
  // falling edge the registered byte is valid
  assign data_o = rd_data;
  assign data_oe_n_o = !((state_r == BUS_READ) && rd_level);

  // ==========================================================
  // Interrupt and auxiliary pins
  // ==========================================================
  always_comb begin
    if (strobe_mode) begin
      chan_a_irq_o = chan_a_irq_req_i;
      chan_a_irq_oe_n_o = !ctrl_a_r[IRQ_EN_BIT];
      chan_b_irq_o = chan_b_irq_req_i;
      chan_b_irq_oe_n_o = !ctrl_b_r[IRQ_EN_BIT];
    end else begin
      // Open drain: only ever pull low, pull-up gives the high
      chan_a_irq_o = 1'b0;
      chan_a_irq_oe_n_o = !(chan_a_irq_req_i || chan_b_irq_req_i);
      chan_b_irq_o = 1'b0;
      chan_b_irq_oe_n_o = 1'b0;
    end
  end

  // Aux outputs follow the inverse of the enable bit in both modes
  assign chan_a_aux_out_n_o = !ctrl_a_r[IRQ_EN_BIT];
  assign chan_b_aux_out_n_o = !ctrl_b_r[IRQ_EN_BIT];

  // ==========================================================
  // Checks
  // ==========================================================
  // A write seen open at one edge and closed at the next
  sequence write_open_s;
    wr_level ##1 !wr_level;
  endsequence

  read_drive_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    rd_start |=> (!data_oe_n_o || !rd_level))
    else $error("read data not driven after read start");
  // Judged from the strobe pins, so a slip in the level decode shows
  bus_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!selected || (strobe_mode ? read_strobe_n_i
      : (write_strobe_n_i != DIR_READ))) |-> data_oe_n_o)
    else $error("data bus driven outside a read");
  write_commit_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    write_open_s |-> wr_done)
    else $error("write not committed at strobe rise");
  dir_ignore_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!strobe_mode && chan_a_select_n_i) |-> (!rd_level && !wr_level))
    else $error("access without device select");
  irq_enable_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    strobe_mode |-> (chan_a_irq_oe_n_o == chan_a_aux_out_n_o))
    else $error("irq enable and aux output disagree");
  irq_b_low_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !strobe_mode |-> (!chan_b_irq_o && !chan_b_irq_oe_n_o))
    else $error("channel B irq not held low");
  open_drain_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !strobe_mode |-> !chan_a_irq_o)
    else $error("shared irq driven high");
  ctrl_update_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_done && idx_r == MODEM_CTRL_IDX && !wr_addr_r[ADDR_W-1])
      |=> (ctrl_a_r == $past(wr_data_r)))
    else $error("channel A control shadow not updated");
  chan_pick_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!strobe_mode && wr_level)
      |=> (wr_addr_r[ADDR_W-1] == $past(chan_b_select_n_i)))
    else $error("channel bit not used in direction mode");
endmodule // dual_channel_host_bus_port
`default_nettype wire

// ---- host_cpu_model.sv ----
// Host processor model that runs byte cycles on the host bus port
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  // Clock and bus style
  input wire logic core_clk_i,
  input wire logic style_i,
  // Pins toward the device
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic chan_a_select_n_o,
  output logic chan_b_select_n_o,
  output logic [2:0] register_index_o,
  output logic [7:0] bus_o,
  // Device side of the data bus
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i
);
  logic [7:0] drv_r = 8'h00;
  logic drv_en_r = 1'b0;
  // ==================================================
  // Data wire: no pull, so a released bus shows the inverse byte
  assign bus_o = !dev_oe_n_i ? dev_data_i :
                 (drv_en_r ? drv_r : ~drv_r);
  // Idle pins; read strobe stays high outside strobe mode
  initial begin
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    chan_a_select_n_o = 1'b1;
    chan_b_select_n_o = 1'b1;
    register_index_o = 3'h0;
  end
  // ==================================================
  // One byte cycle, held until the answer, then idle gap
  task automatic access(input logic wr, input logic ch,
      input logic [2:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output bit ok);
    int n;
    ok = 1'b1;
    rd = 8'h00;
    @(posedge core_clk_i);
    register_index_o <= idx;
    drv_r <= wd;
    drv_en_r <= wr;
    if (style_i) begin
      // Only one channel select at a time
      chan_a_select_n_o <= ch;
      chan_b_select_n_o <= !ch;
      if (wr) write_strobe_n_o <= 1'b0;
      else read_strobe_n_o <= 1'b0;
    end else begin
      chan_a_select_n_o <= 1'b0;
      chan_b_select_n_o <= ch;
      write_strobe_n_o <= !wr;
    end
    if (wr) begin
      repeat (2) @(posedge core_clk_i);
    end else begin
      n = 0;
      @(posedge core_clk_i);
      while (dev_oe_n_i !== 1'b0 && n < 8) begin
        @(posedge core_clk_i);
        n++;
      end
      ok = (n < 8);
      rd = dev_data_i;
    end
    // Release strobes, selects and data drive at the capture edge; the index stays
    read_strobe_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    chan_a_select_n_o <= 1'b1;
    chan_b_select_n_o <= 1'b1;
    drv_en_r <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule // host_cpu_model
`default_nettype wire

// ---- dual_channel_host_bus_port_bench.sv ----
// Self-checking bench for the dual-channel host bus port
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_bus_port_bench;
  import host_port_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic bus_style_i = 1'b1;
  logic req_a = 1'b0;
  logic req_b = 1'b0;
  logic rd_n, wr_n, sel_a_n, sel_b_n, oe_n, irq_a, irq_a_oe_n;
  logic irq_b, irq_b_oe_n, aux_a_n, aux_b_n;
  logic [2:0] idx;
  logic [7:0] bus, dout;
  logic [7:0] shadow [2][8];
  logic [31:0] seed = 32'h8;
  int fail_count = 0;
  int tests_run = 0;
  // ==================================================
  // Clock, design and host model
  always #10 core_clk_i = ~core_clk_i;
  dual_channel_host_bus_port dut (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .bus_style_i(bus_style_i),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .chan_a_select_n_i(sel_a_n), .chan_b_select_n_i(sel_b_n),
    .register_index_i(idx), .data_i(bus), .data_o(dout),
    .data_oe_n_o(oe_n), .chan_a_irq_req_i(req_a),
    .chan_b_irq_req_i(req_b), .chan_a_irq_o(irq_a),
    .chan_a_irq_oe_n_o(irq_a_oe_n), .chan_b_irq_o(irq_b),
    .chan_b_irq_oe_n_o(irq_b_oe_n), .chan_a_aux_out_n_o(aux_a_n),
    .chan_b_aux_out_n_o(aux_b_n));
  host_cpu_model host (.core_clk_i(core_clk_i), .style_i(bus_style_i),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .chan_a_select_n_o(sel_a_n), .chan_b_select_n_o(sel_b_n),
    .register_index_o(idx), .bus_o(bus), .dev_data_i(dout),
    .dev_oe_n_i(oe_n));
  // ==================================================
  // Helpers: random source, compares, verdict
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got,
      input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s %h/%h", $time, what, exp, got);
    end
  endtask
  task automatic check_bit(input logic exp, input logic got,
      input string what);
    check_byte({7'h0, exp}, {7'h0, got}, what);
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Expected irq enable of one channel, from its shadow control byte
  function automatic logic en_of(input int c);
    return shadow[c][MODEM_CTRL_IDX][IRQ_EN_BIT];
  endfunction
  // Pin levels expected from the shadow control bits
  task automatic check_pins();
    logic ea, eb;
    ea = en_of(0);
    eb = en_of(1);
    check_bit(!ea, aux_a_n, "aux a");
    check_bit(!eb, aux_b_n, "aux b");
    check_bit(1'b1, oe_n, "bus released");
    if (bus_style_i) begin
      check_bit(!ea, irq_a_oe_n, "irq a en");
      check_bit(!eb, irq_b_oe_n, "irq b en");
      if (ea) check_bit(req_a, irq_a, "irq a");
      if (eb) check_bit(req_b, irq_b, "irq b");
    end else begin
      // Pulled-up open-drain wire level
      check_bit(!(req_a | req_b), irq_a_oe_n ? 1'b1 : irq_a,
        "shared irq");
      check_bit(1'b0, irq_b_oe_n, "irq b en");
      check_bit(1'b0, irq_b, "irq b");
    end
  endtask
  // ==================================================
  // Fill all 16 bytes, read them back, then random traffic;
  // control bit 3 is set and cleared per channel across modes
  task automatic run_mode(input logic style, input int n);
    logic [31:0] r;
    logic [7:0] got, wd;
    logic [3:0] a;
    logic wr;
    bit ok;
    @(posedge core_clk_i);
    bus_style_i <= style;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      r = next_rand();
      a = (i < 32) ? i[3:0] : r[3:0];
      wr = (i < 16) || (i >= 32 && r[4]);
      wd = r[15:8];
      if (i < 16 && a[2:0] == MODEM_CTRL_IDX) wd[IRQ_EN_BIT] = style ^ a[3];
      // Requests change on a rising edge, never at the check edge
      @(posedge core_clk_i);
      req_a <= r[16];
      req_b <= r[17];
      host.access(wr, a[3], a[2:0], wd, got, ok);
      if (!ok) begin
        fail_count++;
        $display("mismatch at %0t: read timed out", $time);
        close_out();
      end
      if (wr) shadow[a[3]][a[2:0]] = wd;
      else check_byte(shadow[a[3]][a[2:0]], got, "read");
      @(negedge core_clk_i);
      check_pins();
    end
    $display("test done: style %0d", style);
  endtask
  // ==================================================
  // Main sequence
  initial begin
    foreach (shadow[c, k]) shadow[c][k] = REG_RESET_VAL;
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(negedge core_clk_i);
    check_pins();
    $display("test done: reset");
    run_mode(STYLE_STROBE, 64);
    // Mid-run reset must drop control bits left by strobe traffic
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    foreach (shadow[c, k]) shadow[c][k] = REG_RESET_VAL;
    @(negedge core_clk_i);
    check_pins();
    $display("test done: mid reset");
    run_mode(!STYLE_STROBE, 64);
    close_out();
  end
endmodule // dual_channel_host_bus_port_bench
`default_nettype wire
